// >>> rtes_cfg.svh
`ifndef RTES_CFG_SVH
`define RTES_CFG_SVH

// ----------------------------------------
// Host port, channel and counter geometry
// ----------------------------------------
`define RTES_ADDR_W        15
`define RTES_DATA_W        16
`define RTES_NUM_FLAGS     8
`define RTES_CHAN_W        10
`define RTES_NUM_CHANNELS  1024
`define RTES_COUNT_W       16

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTES_OFS_ERROR_FLAGS   15'h0902
`define RTES_OFS_IRQ_ENABLE    15'h0904
`define RTES_OFS_CHAN_MONITOR  15'h0908

// ----------------------------------------
// Reset values and fixed fields
// ----------------------------------------
`define RTES_RST_ERROR_FLAGS   8'h00
`define RTES_RST_IRQ_ENABLE    8'h00
`define RTES_RST_CHAN_MONITOR  10'h000
`define RTES_RST_COUNT         16'h0000
`define RTES_COUNT_MAX         16'hFFFF
`define RTES_COUNT_STEP        16'h0001
`define RTES_PAD_FLAGS         8'h00
`define RTES_PAD_MONITOR       6'h00
`define RTES_ZERO_DATA         16'h0000

`endif

// >>> rtes_checker.sv
`timescale 1ns/10ps
`include "rtes_cfg.svh"

module rtes_checker (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire rtes_pkg::rtes_host_req_t host_req,
    input wire logic [`RTES_DATA_W-1:0]  host_rdata,
    input wire logic                     host_ready,
    input wire logic                     list_manager_fault,
    input wire rtes_pkg::rtes_starve_t   starve,
    input wire logic                     egress_read_cache_overrun,
    input wire logic                     egress_write_cache_overrun,
    input wire logic                     writeback_store_overrun,
    input wire logic                     egress_data_queue_overrun,
    input wire logic                     reassembly_pointer_queue_overrun,
    input wire rtes_pkg::rtes_flags_t    irq_req,
    input wire logic                     irq,
    input wire logic                     fatal_error,
    input wire rtes_pkg::rtes_flags_t    error_flags
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Events in flag order; the wrap bit has no direct input
    logic [7:0] ev_vec;
    logic       rd_flags;
    logic       any_acc;
    assign ev_vec   = {reassembly_pointer_queue_overrun, egress_data_queue_overrun,
                       writeback_store_overrun, egress_write_cache_overrun,
                       egress_read_cache_overrun, 1'b0, starve.valid, list_manager_fault};
    assign rd_flags = host_req.cs && host_req.rd && host_req.addr == `RTES_OFS_ERROR_FLAGS;
    assign any_acc  = host_req.cs && (host_req.rd || host_req.wr);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_flag_read;
        rd_flags ##1 host_ready;
    endsequence
    sequence s_mon_read;
        host_req.cs && host_req.rd && host_req.addr == `RTES_OFS_CHAN_MONITOR ##1 host_ready;
    endsequence

    AST_READY_PULSE: assert property (any_acc |=> host_ready)
        else $error("ready missing after access");
    AST_READY_IDLE: assert property (!any_acc |=> !host_ready)
        else $error("ready without access");
    AST_FLAG_READ: assert property (s_flag_read |-> host_rdata == {8'h00, error_flags})
        else $error("flag read differs from flags");
    AST_MON_PAD: assert property (s_mon_read |-> host_rdata[15:10] == 6'h00)
        else $error("monitor upper bits set");
    AST_IRQ_OR: assert property (irq == (irq_req != 8'h00))
        else $error("irq differs from requests");
    AST_IRQ_MASK: assert property ((irq_req & ~error_flags) == 8'h00)
        else $error("request without flag");
    AST_FATAL: assert property (fatal_error == (|(error_flags & 8'hD8)))
        else $error("fatal summary wrong");
    AST_SET: assert property (ev_vec != 8'h00 |-> ##2
        ((error_flags & $past(ev_vec, 2)) == $past(ev_vec, 2)))
        else $error("event did not set flag");
    AST_STICKY: assert property (($past(error_flags) & ~error_flags) != 8'h00
        |-> $past(rd_flags, 2))
        else $error("flag dropped without read");
endmodule : rtes_checker

bind rtes_error_status rtes_checker u_chk (.clk, .rst_n, .host_req, .host_rdata, .host_ready,
    .list_manager_fault, .starve, .egress_read_cache_overrun, .egress_write_cache_overrun,
    .writeback_store_overrun, .egress_data_queue_overrun, .reassembly_pointer_queue_overrun,
    .irq_req, .irq, .fatal_error, .error_flags);

// >>> rtes_error_status.sv
`timescale 1ns/10ps
`include "rtes_cfg.svh"

module rtes_error_status (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Host register port
    input  wire rtes_pkg::rtes_host_req_t   host_req,
    output logic [`RTES_DATA_W-1:0]         host_rdata,
    output logic                            host_ready,
    // Datapath events
    input  wire logic                       list_manager_fault,
    input  wire rtes_pkg::rtes_starve_t     starve,
    input  wire logic                       egress_read_cache_overrun,
    input  wire logic                       egress_write_cache_overrun,
    input  wire logic                       writeback_store_overrun,
    input  wire logic                       egress_data_queue_overrun,
    input  wire logic                       reassembly_pointer_queue_overrun,
    // Interrupt and summary outputs
    output rtes_pkg::rtes_flags_t           irq_req,
    output logic                            irq,
    output logic                            fatal_error,
    output rtes_pkg::rtes_flags_t           error_flags
);

    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    rtes_pkg::rtes_flags_t          flag_set;
    rtes_pkg::rtes_flags_t          flag_clear;
    rtes_pkg::rtes_flags_t          flags;
    rtes_pkg::rtes_flags_t          irq_enable;
    logic [`RTES_CHAN_W-1:0]        chan_monitor;
    logic                           starve_wrap;
    logic                           sel_flags;
    logic                           sel_enable;
    logic                           sel_monitor;
    logic                           rd_access;
    logic                           wr_access;
    logic [`RTES_DATA_W-1:0]        next_rdata;
    rtes_pkg::rtes_flags_t          next_irq_req;
    logic                           next_fatal;

    // ----------------------------------------
    // Starvation counters
    // ----------------------------------------
    rtes_starve_counters u_counters (
        .clk    (clk),
        .rst_n  (rst_n),
        .starve (starve),
        .wrap   (starve_wrap)
    );

    // ----------------------------------------
    // Event to flag mapping
    // ----------------------------------------
    // Each event pulse lands on its own flag position
    always_comb begin
        flag_set.list_manager_fault               = list_manager_fault;
        flag_set.channel_starvation               = starve.valid;
        flag_set.starvation_rollover              = starve_wrap;
        flag_set.egress_read_cache_overrun        = egress_read_cache_overrun;
        flag_set.egress_write_cache_overrun       = egress_write_cache_overrun;
        flag_set.writeback_store_overrun          = writeback_store_overrun;
        flag_set.egress_data_queue_overrun        = egress_data_queue_overrun;
        flag_set.reassembly_pointer_queue_overrun = reassembly_pointer_queue_overrun;
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Strobes only count while chip select is high
    always_comb begin
        rd_access   = host_req.cs && host_req.rd;
        wr_access   = host_req.cs && host_req.wr && !host_req.rd;
        sel_flags   = host_req.addr == `RTES_OFS_ERROR_FLAGS;
        sel_enable  = host_req.addr == `RTES_OFS_IRQ_ENABLE;
        sel_monitor = host_req.addr == `RTES_OFS_CHAN_MONITOR;
    end

    // Clear on read: only bits shown to the host are dropped
    always_comb begin
        if (rd_access && sel_flags) begin
            flag_clear = flags;
        end else begin
            flag_clear = rtes_pkg::rtes_flags_t'(`RTES_RST_ERROR_FLAGS);
        end
    end

    // ----------------------------------------
    // Sticky flag storage
    // ----------------------------------------
    rtes_flag_bank u_flags (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (flag_set),
        .clear (flag_clear),
        .flags (flags)
    );

    // ----------------------------------------
    // Interrupt enable register
    // ----------------------------------------
    // Upper byte of the write is dropped, not stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_enable <= rtes_pkg::rtes_flags_t'(`RTES_RST_IRQ_ENABLE);
        end else if (wr_access && sel_enable) begin
            irq_enable <= host_req.wdata[`RTES_NUM_FLAGS-1:0];
        end
    end

    // ----------------------------------------
    // Channel monitor
    // ----------------------------------------
    // A wrap is always a starvation too, so the starving channel
    // index covers both cases without waiting for the wrap pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chan_monitor <= `RTES_RST_CHAN_MONITOR;
        end else if (starve.valid) begin
            chan_monitor <= starve.channel;
        end
    end

    // ----------------------------------------
    // Read data path
    // ----------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        next_rdata = `RTES_ZERO_DATA;
        if (sel_flags) begin
            next_rdata = {`RTES_PAD_FLAGS, flags};
        end else if (sel_enable) begin
            next_rdata = {`RTES_PAD_FLAGS, irq_enable};
        end else if (sel_monitor) begin
            next_rdata = {`RTES_PAD_MONITOR, chan_monitor};
        end
    end

    // Read data held until the next read; ready pulses once per access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_rdata <= `RTES_ZERO_DATA;
        end else if (rd_access) begin
            host_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_ready <= 1'b0;
        end else begin
            host_ready <= rd_access || wr_access;
        end
    end

    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------
    // Per-flag request, one cycle behind the flag or enable change
    always_comb begin
        next_irq_req = flags & irq_enable;
        next_fatal   = flags.egress_read_cache_overrun
                     | flags.egress_write_cache_overrun
                     | flags.egress_data_queue_overrun
                     | flags.reassembly_pointer_queue_overrun;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_req <= rtes_pkg::rtes_flags_t'(`RTES_RST_ERROR_FLAGS);
            irq     <= 1'b0;
        end else begin
            irq_req <= next_irq_req;
            irq     <= |next_irq_req;
        end
    end

    // Fatal summary excludes the write-back store overrun
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fatal_error <= 1'b0;
        end else begin
            fatal_error <= next_fatal;
        end
    end

    // Flag mirror for the datapath, registered so outputs come from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            error_flags <= rtes_pkg::rtes_flags_t'(`RTES_RST_ERROR_FLAGS);
        end else begin
            error_flags <= flags;
        end
    end

endmodule : rtes_error_status

// >>> rtes_error_status_tb_top.sv
`timescale 1ns/10ps
`include "rtes_cfg.svh"

module rtes_error_status_tb_top;
    logic                     clk;
    logic                     rst_n;
    rtes_pkg::rtes_host_req_t host_req;
    logic [15:0]              host_rdata;
    logic                     host_ready;
    logic                     list_manager_fault;
    rtes_pkg::rtes_starve_t   starve;
    logic [4:0]               ovr;
    rtes_pkg::rtes_flags_t    irq_req;
    rtes_pkg::rtes_flags_t    error_flags;
    logic                     irq;
    logic                     fatal_error;
    int                       num_errors;
    int                       n_compared;
    int                       cyc;
    logic [15:0]              q;
    logic [7:0]               e;
    logic [7:0]               en;
    logic [9:0]               ch;
    logic [14:0]              ofs [4] = '{15'h0902, 15'h0904, 15'h0908, 15'h0906};

    rtes_error_status DUT (.clk(clk), .rst_n(rst_n), .host_req(host_req),
        .host_rdata(host_rdata), .host_ready(host_ready),
        .list_manager_fault(list_manager_fault), .starve(starve),
        .egress_read_cache_overrun(ovr[0]), .egress_write_cache_overrun(ovr[1]),
        .writeback_store_overrun(ovr[2]), .egress_data_queue_overrun(ovr[3]),
        .reassembly_pointer_queue_overrun(ovr[4]), .irq_req(irq_req), .irq(irq),
        .fatal_error(fatal_error), .error_flags(error_flags));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Wrap test alone needs 65536 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            $display("unexpected timeout expected finish seen hang");
            test_done();
        end
    end

    function automatic logic [15:0] fatal_of(input logic [7:0] f);
        return {15'h0000, |(f & 8'hD8)};
    endfunction : fatal_of

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One host access; ready and data land on the taking edge and are sampled 5 ns after it
    task automatic acc(input logic w, input logic [14:0] a, input logic [15:0] d);
        @(posedge clk);
        #5;
        host_req = '{cs: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        #5;
        host_req = '0;
        chk("ready", 16'h0001, {15'h0000, host_ready});
        q = host_rdata;
    endtask : acc

    task automatic ev(input logic [7:0] f, input logic [9:0] c);
        @(posedge clk);
        #5;
        list_manager_fault = f[0];
        starve = '{valid: f[1], channel: c};
        ovr = f[7:3];
        @(posedge clk);
        #5;
        list_manager_fault = 1'b0;
        starve.valid = 1'b0;
        ovr = 5'h00;
    endtask : ev

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        host_req = '0;
        list_manager_fault = 1'b0;
        starve = '0;
        ovr = 5'h00;
        rst_n = 1'b0;
        num_errors = 0;
        n_compared = 0;
        cyc = 0;
        void'($urandom(93));
        repeat (4) @(posedge clk);
        #5;
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, ofs[i], 16'h0000);
            chk("reset value", 16'h0000, q);
        end
        acc(1'b1, `RTES_OFS_IRQ_ENABLE, 16'hFFAB);
        acc(1'b0, `RTES_OFS_IRQ_ENABLE, 16'h0000);
        chk("enable", 16'h00AB, q);
        $display("test reset and enable done");
        // Single causes first, then random mixes; wrap bit has no cause here
        for (int i = 0; i < 24; i++) begin
            e = (i < 8) ? (8'h01 << i) : 8'($urandom);
            e[2] = 1'b0;
            en = 8'($urandom);
            ch = 10'($urandom % 1023);
            acc(1'b1, `RTES_OFS_IRQ_ENABLE, {8'($urandom), en});
            ev(e, ch);
            repeat (3) @(posedge clk);
            #5;
            chk("irq_req", {8'h00, e & en}, {8'h00, irq_req});
            chk("irq", {15'h0000, |(e & en)}, {15'h0000, irq});
            chk("fatal", fatal_of(e), {15'h0000, fatal_error});
            acc(1'b0, `RTES_OFS_ERROR_FLAGS, 16'h0000);
            chk("flags", {8'h00, e}, q);
            acc(1'b0, `RTES_OFS_ERROR_FLAGS, 16'h0000);
            chk("flags cleared", 16'h0000, q);
            if (e[1]) begin
                acc(1'b0, `RTES_OFS_CHAN_MONITOR, 16'h0000);
                chk("monitor", {6'h00, ch}, q);
            end
        end
        $display("test flags done");
        // Top channel is untouched above, so its count starts at zero
        @(posedge clk);
        #5;
        starve = '{valid: 1'b1, channel: 10'h3FF};
        repeat (65535) @(posedge clk);
        #5;
        starve.valid = 1'b0;
        acc(1'b0, `RTES_OFS_ERROR_FLAGS, 16'h0000);
        chk("no wrap yet", 16'h0002, q);
        ev(8'h02, 10'h3FF);
        repeat (2) @(posedge clk);
        acc(1'b0, `RTES_OFS_ERROR_FLAGS, 16'h0000);
        chk("wrap", 16'h0006, q);
        acc(1'b0, `RTES_OFS_CHAN_MONITOR, 16'h0000);
        chk("wrap channel", 16'h03FF, q);
        $display("test wrap done");
        // Fault pulse on the very edge of the clearing read must survive it
        ev(8'h01, 10'h000);
        @(posedge clk);
        #5;
        host_req = '{cs: 1'b1, rd: 1'b1, wr: 1'b0, addr: `RTES_OFS_ERROR_FLAGS, wdata: 16'h0000};
        list_manager_fault = 1'b1;
        @(posedge clk);
        #5;
        host_req = '0;
        list_manager_fault = 1'b0;
        chk("clearing read", 16'h0001, host_rdata);
        acc(1'b0, `RTES_OFS_ERROR_FLAGS, 16'h0000);
        chk("set beats clear", 16'h0001, q);
        acc(1'b0, `RTES_OFS_ERROR_FLAGS, 16'h0000);
        chk("cleared after", 16'h0000, q);
        $display("test set against clear done");
        test_done();
    end
endmodule : rtes_error_status_tb_top

// >>> rtes_flag_bank.sv
`timescale 1ns/10ps
`include "rtes_cfg.svh"

module rtes_flag_bank (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire rtes_pkg::rtes_flags_t   set,
    input  wire rtes_pkg::rtes_flags_t   clear,
    output rtes_pkg::rtes_flags_t        flags
);

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    // Set beats clear so an event landing on the clearing read is kept
    for (genvar b = 0; b < `RTES_NUM_FLAGS; b++) begin : g_flag
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                flags[b] <= 1'b0;
            end else if (set[b]) begin
                flags[b] <= 1'b1;
            end else if (clear[b]) begin
                flags[b] <= 1'b0;
            end
        end
    end

endmodule : rtes_flag_bank

// >>> rtes_pkg.sv
`include "rtes_cfg.svh"

package rtes_pkg;

    // Flag vector, one bit per flag position; used for event pulses, sticky flags, enables and requests
    typedef struct packed {
        logic reassembly_pointer_queue_overrun;
        logic egress_data_queue_overrun;
        logic writeback_store_overrun;
        logic egress_write_cache_overrun;
        logic egress_read_cache_overrun;
        logic starvation_rollover;
        logic channel_starvation;
        logic list_manager_fault;
    } rtes_flags_t;

    // Host access request
    typedef struct packed {
        logic                       cs;
        logic                       rd;
        logic                       wr;
        logic [`RTES_ADDR_W-1:0]    addr;
        logic [`RTES_DATA_W-1:0]    wdata;
    } rtes_host_req_t;

    // Starvation report from the egress datapath
    typedef struct packed {
        logic                       valid;
        logic [`RTES_CHAN_W-1:0]    channel;
    } rtes_starve_t;

endpackage : rtes_pkg

// >>> rtes_starve_counters.sv
`timescale 1ns/10ps
`include "rtes_cfg.svh"

module rtes_starve_counters (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire rtes_pkg::rtes_starve_t  starve,
    output logic                         wrap
);

    // ----------------------------------------
    // Per-channel counters
    // ----------------------------------------
    logic [`RTES_COUNT_W-1:0] count [`RTES_NUM_CHANNELS];

    // One counter per channel; only the addressed one moves
    for (genvar ch = 0; ch < `RTES_NUM_CHANNELS; ch++) begin : g_chan
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                count[ch] <= `RTES_RST_COUNT;
            end else if (starve.valid && starve.channel == (`RTES_CHAN_W)'(ch)) begin
                count[ch] <= count[ch] + `RTES_COUNT_STEP;
            end
        end
    end

    // Wrap pulse: counter at its maximum takes one more starvation
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrap <= 1'b0;
        end else begin
            wrap <= starve.valid && (count[starve.channel] == `RTES_COUNT_MAX);
        end
    end

endmodule : rtes_starve_counters
